// ==== rtl/uls_pkg.sv ====
// Purpose: shared constants for line and modem status logic
// Assumes: AXI4-Lite slave with 32-bit data, one register per word
// Notes: register offsets are byte addresses
// Contract
// - Line status bit 7 stays high while any FIFO entry holds an error flag.
// - Line status bit 6 high only when holding and shift registers are both empty.
// - Line status bit 5 high when holding register empty; host may load 64.
// - A break stores character 0x00 with a break flag, shown in bit 4.
// - Bit 3 flags a character whose stop bit was sampled low.
// - Bit 2 flags a character whose parity check failed.
// - Bit 1 sets when a receive overrun occurs.
// - Bit 0 high while the receive FIFO holds at least one character.
// - Each entry keeps its flags; bits 4:2 show the head entry's flags.
// - Modem status bit 7 is the inverted carrier-detect pin when mapped.
// - Modem status bit 6 is the inverted ring-indicator pin when mapped.
// - Modem status bit 5 is the inverted data-set-ready pin when mapped.
// - Pins mapped to modem use need not read back in the pin level register.
// - Modem status bit 4 is the inverted clear-to-send input.
// - Bits 3, 1, 0 latch changes of CD, DSR, CTS; cleared by modem status read.
// - Bit 2 latches a low-to-high ring input change; cleared by modem status read.
// - Loopback routes DTR and RTS settings into bits 5 and 4, loops TX to RX.
package uls_pkg;
    localparam logic [7:0] OFS_RXH = 8'h00;
    localparam logic [7:0] OFS_LS  = 8'h04;
    localparam logic [7:0] OFS_MS  = 8'h08;
    localparam logic [7:0] OFS_MC  = 8'h0c;
    localparam logic [7:0] OFS_PF  = 8'h10;
    localparam logic [7:0] OFS_GL  = 8'h14;
    localparam logic [7:0] MC_RST  = 8'h00;
    localparam logic [7:0] PF_RST  = 8'h00;
    localparam logic [7:0] BRK_CHAR = 8'h00;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam int MC_DTR  = 0;
    localparam int MC_RTS  = 1;
    localparam int MC_LOOP = 4;
    localparam int PF_HI   = 1;
    localparam int PF_LO   = 2;
    localparam int E_PAR   = 8;
    localparam int E_BRK   = 10;
    localparam int GP_CD_HI  = 6;
    localparam int GP_CD_LO  = 2;
    localparam int GP_RI_HI  = 7;
    localparam int GP_RI_LO  = 3;
    localparam int GP_DSR_HI = 4;
    localparam int GP_DSR_LO = 0;
endpackage

// ==== rtl/uls_msr_if.sv ====
// Purpose: carrier between register block and modem status logic
// Assumes: both ends on the same clock
// Notes: mstat comes from flip-flops; gpio_lvl is masked combinationally
`timescale 1ns/100ps
interface uls_mstat_if;
    logic       map_hi;
    logic       map_lo;
    logic       loopback;
    logic       dtr;
    logic       rts;
    logic       rd_clr;
    logic [7:0] mstat;
    logic [7:0] gpio_lvl;
    modport regs (output map_hi, map_lo, loopback, dtr, rts, rd_clr,
                  input mstat, gpio_lvl);
    modport stat (input map_hi, map_lo, loopback, dtr, rts, rd_clr,
                  output mstat, gpio_lvl);
endinterface

// ==== rtl/uls_modem_stat.sv ====
// Purpose: modem status bits, delta flags and pin synchronisers
// Assumes: pins are asynchronous, active low
// Notes: upper pin group wins when both groups are mapped
`timescale 1ns/100ps
module uls_modem_stat import uls_pkg::*; (
    // Clock and reset
    input wire logic       clock,
    input wire logic       rstn,
    // Pins
    input wire logic [7:0] gpio_in,
    input wire logic       cts_n,
    // Register side
    uls_mstat_if.stat      mif
);
    logic [8:0] raw;
    logic [8:0] s1_r, s2_r, s3_r, lvl_r;
    logic [3:0] st_r, st_nxt, dl_r, dl_nxt, ev;
    logic       cd, ri, dsr, cts;

    assign raw = {cts_n, gpio_in};
    for (genvar i = 0; i < 9; i++) begin : g_sync
        always_ff @(posedge clock) begin
            if (!rstn) begin
                s1_r[i]  <= 1'b1;
                s2_r[i]  <= 1'b1;
                s3_r[i]  <= 1'b1;
                lvl_r[i] <= 1'b1;
            end else begin
                s1_r[i] <= raw[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                if (s2_r[i] == s3_r[i]) begin
                    lvl_r[i] <= s3_r[i];
                end
            end
        end
    end

    // Loopback ignores the pins; CD and RI read inactive then
    assign cd  = !mif.loopback & (mif.map_hi ? !lvl_r[GP_CD_HI] :
                 mif.map_lo & !lvl_r[GP_CD_LO]);
    assign ri  = !mif.loopback & (mif.map_hi ? !lvl_r[GP_RI_HI] :
                 mif.map_lo & !lvl_r[GP_RI_LO]);
    assign dsr = mif.loopback ? mif.dtr : (mif.map_hi ? !lvl_r[GP_DSR_HI] :
                 mif.map_lo & !lvl_r[GP_DSR_LO]);
    assign cts = mif.loopback ? mif.rts : !lvl_r[8];
    assign st_nxt = {cd, ri, dsr, cts};
    assign ev = {cd ^ st_r[3], st_r[2] & !ri, dsr ^ st_r[1], cts ^ st_r[0]};
    // A change in the read cycle stays latched: set wins over clear
    assign dl_nxt = (dl_r & {4{!mif.rd_clr}}) | ev;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_r <= 4'h0;
            dl_r <= 4'h0;
        end else begin
            st_r <= st_nxt;
            dl_r <= dl_nxt;
        end
    end

    assign mif.mstat = {st_r, dl_r};
    // Modem pins read back as zero
    assign mif.gpio_lvl = lvl_r[7:0] & ~{{4{mif.map_hi}}, {4{mif.map_lo}}};

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_loop_cts: assert property (mif.loopback && mif.rts |=> mif.mstat[4])
        else $error("loopback rts not seen in cts bit");
    a_ri_delta: assert property ($fell(mif.mstat[6]) |-> mif.mstat[2])
        else $error("ring delta missing on falling ring bit");
    a_delta_clr: assert property (mif.rd_clr && ev == 4'h0 |=> mif.mstat[3:0] == 4'h0)
        else $error("delta flags not cleared by read");
    a_cts_pin: assert property (!mif.loopback && lvl_r[8] |=> !mif.mstat[4])
        else $error("cts bit not inverse of pin");
    c_ri_edge: cover property ($fell(mif.mstat[6]));
endmodule

// ==== rtl/uls_top.sv ====
// Purpose: line and modem status registers of one serial channel
// Assumes: receiver and transmitter status inputs are on this clock
// Notes: reading the receive holding register pops the FIFO head
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
module uls_top import uls_pkg::*; #(
    parameter int RX_DEPTH = 64,
    parameter int ADDR_W   = 8
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [31:0]       s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [31:0]            s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    // Receiver framing results
    input  wire logic              rx_char_valid,
    input  wire logic [7:0]        rx_char,
    input  wire logic              rx_parity_err,
    input  wire logic              rx_frame_err,
    input  wire logic              rx_break_det,
    // Transmitter state
    input  wire logic              tx_holding_empty,
    input  wire logic              tx_shift_empty,
    // Modem pins
    input  wire logic [7:0]        gpio_in,
    input  wire logic              cts_n,
    output logic                   dtr_n,
    output logic                   rts_n,
    output logic                   loop_tx_rx
);
    localparam int PW = $clog2(RX_DEPTH);

    logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0]        bresp_r, rresp_r;
    logic [31:0]       rdata_r;
    logic [ADDR_W-1:0] waddr_r;
    logic [7:0]        wdata_r;
    logic              wstb_r;
    logic [7:0]        mc_r, pf_r;
    logic              dtr_n_r, rts_n_r, loop_r, ovr_r, ovr_nxt;
    logic [10:0]       mem_r [RX_DEPTH];
    logic [PW-1:0]     wp_r, rp_r;
    logic [PW:0]       cnt_r, cnt_nxt, ecnt_r, ecnt_nxt;
    logic [7:0]        ls_word;
    logic [7:0]        rd_byte;
    uls_mstat_if       mif();

    // Bus decode
    wire aw_hs  = s_awvalid & awready_r;
    wire w_hs   = s_wvalid & wready_r;
    wire b_hs   = bvalid_r & s_bready;
    wire ar_hs  = s_arvalid & arready_r;
    wire r_hs   = rvalid_r & s_rready;
    wire wr_go  = !awready_r & !wready_r & !bvalid_r;
    wire wa_mc  = waddr_r == ADDR_W'(OFS_MC);
    wire wa_pf  = waddr_r == ADDR_W'(OFS_PF);
    wire wa_ro  = waddr_r == ADDR_W'(OFS_RXH) || waddr_r == ADDR_W'(OFS_LS) ||
                  waddr_r == ADDR_W'(OFS_MS) || waddr_r == ADDR_W'(OFS_GL);
    wire wr_map = wa_mc | wa_pf | wa_ro;
    wire wr_mc  = wr_go & wstb_r & wa_mc;
    wire wr_pf  = wr_go & wstb_r & wa_pf;
    wire ra_rxh = s_araddr == ADDR_W'(OFS_RXH);
    wire ra_ls  = s_araddr == ADDR_W'(OFS_LS);
    wire ra_ms  = s_araddr == ADDR_W'(OFS_MS);
    wire ra_mc  = s_araddr == ADDR_W'(OFS_MC);
    wire ra_pf  = s_araddr == ADDR_W'(OFS_PF);
    wire ra_gl  = s_araddr == ADDR_W'(OFS_GL);
    wire ra_map = ra_rxh | ra_ls | ra_ms | ra_mc | ra_pf | ra_gl;
    wire rd_ls  = ar_hs & ra_ls;

    // Receive FIFO control
    wire [10:0] head   = mem_r[rp_r];
    wire        empty  = cnt_r == '0;
    wire        full   = cnt_r == (PW+1)'(RX_DEPTH);
    wire        pop    = ar_hs & ra_rxh & !empty;
    wire        in_v   = rx_char_valid | rx_break_det;
    wire [10:0] in_e   = rx_break_det ? {1'b1, 2'b00, BRK_CHAR} :
                         {1'b0, rx_frame_err, rx_parity_err, rx_char};
    wire        push   = in_v & (!full | pop);
    wire        ovr_ev = in_v & full & !pop;
    wire        in_err = |in_e[E_BRK:E_PAR];
    wire        hd_err = |head[E_BRK:E_PAR];

    assign cnt_nxt  = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    assign ecnt_nxt = ecnt_r + (PW+1)'(push & in_err) - (PW+1)'(pop & hd_err);
    // Set wins so an overrun in the read cycle is not lost
    assign ovr_nxt  = (ovr_r & !rd_ls) | ovr_ev;

    assign ls_word = {ecnt_r != '0,
                      tx_holding_empty & tx_shift_empty,
                      tx_holding_empty,
                      empty ? 3'h0 : head[E_BRK:E_PAR],
                      ovr_r,
                      !empty};

    // Empty FIFO reads as zero, nothing popped
    assign rd_byte = ra_rxh ? (empty ? 8'h00 : head[7:0]) :
                     ra_ls  ? ls_word :
                     ra_ms  ? mif.mstat :
                     ra_mc  ? mc_r :
                     ra_pf  ? pf_r :
                     ra_gl  ? mif.gpio_lvl : 8'h00;

    assign mif.map_hi   = pf_r[PF_HI];
    assign mif.map_lo   = pf_r[PF_LO];
    assign mif.loopback = mc_r[MC_LOOP];
    assign mif.dtr      = mc_r[MC_DTR];
    assign mif.rts      = mc_r[MC_RTS];
    assign mif.rd_clr   = ar_hs & ra_ms;

    uls_modem_stat u_stat (
        .clock   (clock),
        .rstn    (rstn),
        .gpio_in (gpio_in),
        .cts_n   (cts_n),
        .mif     (mif)
    );

    // Write channel: address and data taken in either order
    always_ff @(posedge clock) begin
        if (!rstn) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OK;
            waddr_r   <= '0;
            wdata_r   <= 8'h00;
            wstb_r    <= 1'b0;
        end else begin
            if (aw_hs) begin
                awready_r <= 1'b0;
                waddr_r   <= s_awaddr;
            end
            if (w_hs) begin
                wready_r <= 1'b0;
                wdata_r  <= s_wdata[7:0];
                wstb_r   <= s_wstrb[0];
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_map ? RESP_OK : RESP_ERR;
            end
            if (b_hs) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // Status registers take no write; only control bytes change
    always_ff @(posedge clock) begin
        if (!rstn) begin
            mc_r <= MC_RST;
            pf_r <= PF_RST;
        end else begin
            if (wr_mc) begin
                mc_r <= wdata_r;
            end
            if (wr_pf) begin
                pf_r <= wdata_r;
            end
        end
    end

    // Read channel: answer in the cycle after the address is taken
    always_ff @(posedge clock) begin
        if (!rstn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= RESP_OK;
        end else if (ar_hs) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= {24'h00_0000, rd_byte};
            rresp_r   <= ra_map ? RESP_OK : RESP_ERR;
        end else if (r_hs) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    // Storage has no reset: only entries below the count are ever read
    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wp_r] <= in_e;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            wp_r   <= '0;
            rp_r   <= '0;
            cnt_r  <= '0;
            ecnt_r <= '0;
            ovr_r  <= 1'b0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == PW'(RX_DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == PW'(RX_DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r  <= cnt_nxt;
            ecnt_r <= ecnt_nxt;
            ovr_r  <= ovr_nxt;
        end
    end

    // DTR and RTS go inactive in loopback so the modem sees nothing
    always_ff @(posedge clock) begin
        if (!rstn) begin
            dtr_n_r <= 1'b1;
            rts_n_r <= 1'b1;
            loop_r  <= 1'b0;
        end else begin
            dtr_n_r <= !mc_r[MC_DTR] | mc_r[MC_LOOP];
            rts_n_r <= !mc_r[MC_RTS] | mc_r[MC_LOOP];
            loop_r  <= mc_r[MC_LOOP];
        end
    end

    assign s_awready  = awready_r;
    assign s_wready   = wready_r;
    assign s_bvalid   = bvalid_r;
    assign s_bresp    = bresp_r;
    assign s_arready  = arready_r;
    assign s_rvalid   = rvalid_r;
    assign s_rdata    = rdata_r;
    assign s_rresp    = rresp_r;
    assign dtr_n      = dtr_n_r;
    assign rts_n      = rts_n_r;
    assign loop_tx_rx = loop_r;

    // Checking helpers
    // Summary reference rebuilt from stored flags, independent of the error counter
    logic any_err_chk;
    always_comb begin
        any_err_chk = 1'b0;
        for (int i = 0; i < RX_DEPTH; i++) begin
            if (i < int'(cnt_r)) begin
                any_err_chk = any_err_chk | (|mem_r[(int'(rp_r) + i) % RX_DEPTH][E_BRK:E_PAR]);
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    a_err_summary: assert property (ls_word[7] == any_err_chk)
        else $error("error summary disagrees with FIFO contents");
    a_tx_empty: assert property (ls_word[6] |-> tx_shift_empty && ls_word[5])
        else $error("transmit empty set with data pending");
    a_thr_empty: assert property (tx_holding_empty |-> ls_word[5])
        else $error("holding empty bit missing");
    a_break_char: assert property (rx_break_det && !full |=> mem_r[$past(wp_r)] == {1'b1, 2'b00, BRK_CHAR})
        else $error("break entry not stored as zero with flag");
    a_frame_flag: assert property (rx_char_valid && !rx_break_det && rx_frame_err && empty
                                   |=> ls_word[3])
        else $error("framing flag not shown at head");
    a_parity_flag: assert property (rx_char_valid && !rx_break_det && rx_parity_err && empty
                                    |=> ls_word[2])
        else $error("parity flag not shown at head");
    a_ovr_set: assert property (in_v && full && !pop
                                |=> ls_word[1] ##1 (ls_word[1] || $past(rd_ls)))
        else $error("overrun not held after push into full FIFO");
    a_data_ready: assert property (push && empty |=> ls_word[0])
        else $error("data ready missing after push");
    a_head_flags: assert property (!empty |-> ls_word[4:2] == mem_r[rp_r][E_BRK:E_PAR])
        else $error("head flags not shown");
    a_ovr_clear: assert property (rd_ls && !ovr_ev |=> !ls_word[1])
        else $error("overrun not cleared by line status read");
    a_ls_ro: assert property (wr_go && waddr_r == ADDR_W'(OFS_LS) |=> $stable(mc_r) && $stable(pf_r))
        else $error("write to line status changed control");
    a_ms_ro: assert property (wr_go && waddr_r == ADDR_W'(OFS_MS) |=> $stable(mc_r) && $stable(pf_r))
        else $error("write to modem status changed control");
    a_loop_out: assert property (mc_r[MC_LOOP] |=> loop_tx_rx && dtr_n && rts_n)
        else $error("loopback not applied to outputs");

    c_overrun: cover property (ovr_ev);
    c_break: cover property (rx_break_det && !full);
    c_pop_err: cover property (pop && hd_err);
    c_wr_rd: cover property (b_hs ##[1:20] r_hs);
endmodule

// ==== test/uls_modem_model.sv ====
// Purpose: modem side driving the active-low control pins
// Assumes: line states change just after a rising clock edge
// Notes: pins not used as modem lines toggle every cycle
`timescale 1ns/100ps
module uls_modem_model (
    // Clock
    input  wire logic       clock,
    // Wanted states, active high: cd, ri, dsr, cts
    input  wire logic [3:0] act,
    input  wire logic       grp_hi,
    // Pins
    output logic [7:0]      gpio_in = 8'hff,
    output logic            cts_n = 1'b1
);
    logic [7:0] spare_r = 8'h5a;
    // Spare pins toggle so that a leak into modem status shows up
    always @(posedge clock) begin
        spare_r <= ~spare_r;
        cts_n   <= ~act[0];
        if (grp_hi) begin
            gpio_in <= {~act[2], ~act[3], spare_r[5], ~act[1], spare_r[3:0]};
        end else begin
            gpio_in <= {spare_r[7:4], ~act[2], ~act[3], spare_r[1], ~act[1]};
        end
    end
endmodule

// ==== test/uart_line_modem_status_tb_top.sv ====
// Purpose: self-checking bench for line and modem status registers
// Assumes: reads and writes go through AXI4-Lite tasks
// Notes: small receive FIFO so overrun comes quickly
`timescale 1ns/100ps
module uart_line_modem_status_tb_top;
    import uls_pkg::*;
    localparam int DEPTH = 8;
    logic        clock = 1'b0, rstn = 1'b0;
    logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00, rx_char = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0]  s_wstrb = 4'h1, act = 4'h0, lvl = 4'h0, dl = 4'h0;
    logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, dtr_n, rts_n, loop_tx_rx, cts_n;
    logic [1:0]  s_bresp, s_rresp, rs;
    logic        rx_char_valid = 1'b0, rx_parity_err = 1'b0, rx_frame_err = 1'b0, rx_break_det = 1'b0;
    logic        txh = 1'b1, txs = 1'b1, grp_hi = 1'b1, ovr = 1'b0;
    logic [7:0]  gpio_in;
    logic [31:0] rd;
    logic [10:0] q[$];
    int          miscompares = 0, compares = 0;

    always #2.5 clock = ~clock;

    uls_top #(.RX_DEPTH(DEPTH), .ADDR_W(8)) i_dut (
        .clock(clock), .rstn(rstn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_parity_err(rx_parity_err),
        .rx_frame_err(rx_frame_err), .rx_break_det(rx_break_det), .tx_holding_empty(txh),
        .tx_shift_empty(txs), .gpio_in(gpio_in), .cts_n(cts_n), .dtr_n(dtr_n), .rts_n(rts_n),
        .loop_tx_rx(loop_tx_rx));

    uls_modem_model i_modem (.clock(clock), .act(act), .grp_hi(grp_hi), .gpio_in(gpio_in), .cts_n(cts_n));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1 && n < 100);
        r = s_bresp;
        s_bready <= 1'b0;
        if (s_bvalid !== 1'b1) miscompares++;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_arready) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1 && n < 100);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
        if (s_rvalid !== 1'b1) miscompares++;
    endtask

    function automatic logic [7:0] exp_ls();
        logic err;
        err = 1'b0;
        foreach (q[i]) err |= |q[i][10:8];
        return {err, txh & txs, txh, (q.size() > 0) ? q[0][10:8] : 3'h0, ovr, q.size() > 0};
    endfunction

    // Ring delta follows the pin going high, so the ring level bit falling
    function automatic void ms_upd(input logic [3:0] nl);
        dl  = dl | (nl ^ lvl) & 4'b1011 | {1'b0, lvl[2] & ~nl[2], 2'b00};
        lvl = nl;
    endfunction

    task automatic push(input logic brk, input logic [31:0] r);
        @(posedge clock);
        rx_break_det  <= brk;
        rx_char_valid <= 1'b1;
        rx_char       <= r[7:0];
        rx_parity_err <= r[8];
        rx_frame_err  <= r[9];
        @(posedge clock);
        rx_break_det  <= 1'b0;
        rx_char_valid <= 1'b0;
        if (q.size() < DEPTH) q.push_back(brk ? {3'b100, BRK_CHAR} : {1'b0, r[9:0]});
        else ovr = 1'b1;
    endtask

    task automatic pop_chk();
        logic [10:0] e;
        axi_rd(OFS_LS, rd, rs);
        check(rd, {24'h0, exp_ls()});
        ovr = 1'b0;
        axi_rd(OFS_RXH, rd, rs);
        e = (q.size() > 0) ? q.pop_front() : 11'h0;
        check(rd, {24'h0, e[7:0]});
    endtask

    task automatic ms_chk();
        repeat (12) @(posedge clock);
        axi_rd(OFS_MS, rd, rs);
        check(rd, {24'h0, lvl, dl});
        dl = 4'h0;
    endtask

    initial begin
        void'($urandom(61));
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            txh <= k[0];
            txs <= k[1];
            axi_rd(OFS_LS, rd, rs);
            check(rd, {24'h0, exp_ls()});
        end
        axi_wr(OFS_LS, 32'hff, rs);
        check(rs, RESP_OK);
        axi_wr(OFS_MS, 32'hff, rs);
        axi_wr(8'h18, 32'h1, rs);
        check(rs, RESP_ERR);
        axi_rd(8'h1c, rd, rs);
        check(rs, RESP_ERR);
        check(rd, 32'h0);
        repeat (6) begin
            repeat (1 + $urandom_range(DEPTH - 1)) push($urandom_range(3) == 0, $urandom);
            while (q.size() > 0) pop_chk();
        end
        repeat (DEPTH + 2) push(1'b0, $urandom);
        repeat (DEPTH + 1) pop_chk();
        for (int m = 0; m < 2; m++) begin
            grp_hi <= (m == 0);
            axi_wr(OFS_PF, 32'h1 << ((m == 0) ? PF_HI : PF_LO), rs);
            for (int k = 0; k < 9; k++) begin
                act <= (k == 8) ? 4'h0 : 4'($urandom);
                @(posedge clock);
                ms_upd(act);
                ms_chk();
            end
            axi_rd(OFS_GL, rd, rs);
            check(rd[7:0] & ((m == 0) ? 8'hd0 : 8'h0d), 8'h00);
        end
        axi_wr(OFS_MC, (32'h1 << MC_LOOP) | (32'h1 << MC_DTR) | (32'h1 << MC_RTS), rs);
        ms_upd(4'b0011);
        ms_chk();
        check({dtr_n, rts_n, loop_tx_rx}, 3'b111);
        axi_wr(OFS_MC, (32'h1 << MC_DTR) | (32'h1 << MC_RTS), rs);
        ms_upd(4'b0000);
        ms_chk();
        check({dtr_n, rts_n, loop_tx_rx}, 3'b000);
        axi_rd(OFS_MC, rd, rs);
        check(rd, 32'h3);
        // Lane 0 strobe low: the write is answered but must not land
        s_wstrb <= 4'h0;
        axi_wr(OFS_MC, 32'h10, rs);
        s_wstrb <= 4'h1;
        axi_rd(OFS_MC, rd, rs);
        check(rd, 32'h3);
        report_and_stop();
    end

    // Run needs well under 20k cycles; allow 60k before calling it hung
    initial begin
        #(5 * 60000);
        miscompares++;
        report_and_stop();
    end
endmodule
